// [inc/sotp_pkg.sv]
// Package for the secured OTP lock control block.
// Assumes a byte-level command front end inside the flash presents opcodes and data.
`default_nettype none
package sotp_pkg;
    localparam logic [7:0]  OP_WR_SEC     = 8'h2f;  // Security register write
    localparam logic [7:0]  OP_ENTER_OTP  = 8'hb1;  // Enter secured OTP mode
    localparam logic [7:0]  OP_EXIT_OTP   = 8'hc1;  // Exit secured OTP mode
    localparam logic [7:0]  OP_WR_STATUS1 = 8'h01;  // Status register-1 write
    localparam logic [7:0]  OP_WR_STATUS2 = 8'h31;  // Status register-2 write
    localparam int          LOCK_BIT      = 1;      // Lock-down bit position
    localparam int          FACT_BIT      = 0;      // Factory-lock bit position
    localparam int          OTP_ADDR_W    = 9;      // 4K bits = 512 bytes
    localparam int          OTP_BYTES     = 512;
    localparam logic [23:0] SERIAL_LAST   = 24'h00000f;  // Serial number region end
    localparam logic [23:0] OTP_LAST      = 24'h0001ff;  // Customer region end
    localparam logic [2:0]  BIT_LAST      = 3'h7;   // Last bit of a byte
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;  // Reset value of OTP cells

    // Completed command byte from the serial front end
    typedef struct packed {
        logic       valid;   // One-cycle pulse per byte
        logic       first;   // Byte is the opcode
        logic [7:0] data;
    } sotp_byte_t;

    // Program or read request after command decode
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [23:0] addr;
        logic [7:0]  data;
    } sotp_acc_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_WSEC = 4'b0010,
        S_DONE = 4'b0100,
        S_SKIP = 4'b1000
    } sotp_state_t;

    // Region of an OTP address: 0 serial, 1 customer, 2 out of range
    function automatic logic [1:0] sotp_region(input logic [23:0] a);
        if (a <= SERIAL_LAST) begin
            return 2'h0;
        end
        if (a <= OTP_LAST) begin
            return 2'h1;
        end
        return 2'h2;
    endfunction : sotp_region
endpackage : sotp_pkg
`default_nettype wire

// [rtl/sotp_ctrl.sv]
// Secured OTP lock control: security register, OTP mode and access gating.
// Assumes a serial front end on CLOCK_IN delivering bytes and deselect events,
// and a nonvolatile store presenting the lock bits at power-up.
`timescale 1ns/1ns
`default_nettype none
module sotp_ctrl
    import sotp_pkg::*;
(
    input  wire logic        CLOCK_IN,         // 20 MHz clock
    input  wire logic        RST_N_IN,         // Async reset, active low
    input  wire sotp_byte_t  BYTE_IN,          // Received command bytes
    input  wire logic        DESEL_IN,         // Chip select rising pulse
    input  wire logic [2:0]  BIT_CNT_IN,       // Bits received of current byte
    input  wire logic        NV_LOCK_IN,       // Stored lock-down bit
    input  wire logic        NV_FACT_IN,       // Stored factory-lock bit
    input  wire logic        NV_LOAD_IN,       // Pulse: nonvolatile bits valid
    input  wire sotp_acc_t   ACC_IN,           // Program/read from array path
    output sotp_acc_t        MAIN_ACC_OUT,     // Access passed to main array
    output logic [7:0]       OTP_RDATA_OUT,    // OTP read data
    output logic [7:0]       SEC_REG_OUT,      // Security register value
    output logic             OTP_MODE_OUT,     // Secured OTP mode active
    output logic             NV_LOCK_WR_OUT,   // Pulse: persist lock-down bit
    output logic             REFUSED_OUT       // Pulse: access refused
);
    sotp_state_t state_q, state_d;
    logic        otp_mode_q;
    logic        lock_q;
    logic        fact_q;
    logic        pend_lock_q;
    logic        nv_wr_q;
    logic        refused_q;
    logic        locked;
    logic        otp_wr_ok;
    logic [1:0]  region;
    logic        opcode_ev;
    logic        op_wsec;
    logic        op_enter;
    logic        op_exit;
    logic        clean_desel;

    // Opcode decode shared by the decoder, the mode flag and the checks
    function automatic logic is_opcode(input sotp_byte_t b, input logic [7:0] code);
        return b.valid && b.first && b.data == code;
    endfunction : is_opcode

    // Clean end of a security write: one data byte seen, deselect on a byte boundary.
    // Anything else leaves the lock untouched, so a glitchy host cannot half-write it.
    function automatic logic clean_end(input sotp_state_t st, input logic desel,
                                       input logic [2:0] bits);
        return st == S_DONE && desel && bits == 3'h0;
    endfunction : clean_end

    // Decoded events used by the logic; all but opcode_ev also feed the checks
    assign locked      = lock_q | fact_q;
    assign opcode_ev   = BYTE_IN.valid & BYTE_IN.first;
    assign region      = sotp_region(ACC_IN.addr);
    assign op_wsec     = is_opcode(BYTE_IN, OP_WR_SEC);
    assign op_enter    = is_opcode(BYTE_IN, OP_ENTER_OTP);
    assign op_exit     = is_opcode(BYTE_IN, OP_EXIT_OTP);
    assign clean_desel = clean_end(state_q, DESEL_IN, BIT_CNT_IN);

    // Lock bits restored from the nonvolatile store; a clean security write also sets lock_q
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            lock_q <= 1'b0;
            fact_q <= 1'b0;
        end else if (NV_LOAD_IN) begin
            lock_q <= NV_LOCK_IN;
            fact_q <= NV_FACT_IN;
        end else if (clean_desel && !locked) begin
            lock_q <= lock_q | pend_lock_q;
        end
    end

    // Security write decoder: opcode, one data byte, then clean deselect
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                // No write-enable latch is consulted here
                if (op_wsec) begin
                    state_d = otp_mode_q ? S_SKIP : S_WSEC;
                end else if (opcode_ev) begin
                    state_d = S_SKIP;
                end
            end
            S_WSEC: if (BYTE_IN.valid) begin
                state_d = S_DONE;
            end
            S_DONE: if (BYTE_IN.valid) begin
                state_d = S_SKIP; // Extra byte breaks the boundary
            end
            S_SKIP: state_d = S_SKIP;
            default: state_d = S_IDLE;
        endcase
        if (DESEL_IN) begin
            state_d = S_IDLE;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Only the lock bit of the data byte is kept; bit 0 and reserved ignored
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pend_lock_q <= 1'b0;
        end else if (state_q == S_WSEC && BYTE_IN.valid) begin
            pend_lock_q <= BYTE_IN.data[LOCK_BIT];
        end
    end

    // Persist pulse only when the bit really changes
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            nv_wr_q <= 1'b0;
        end else begin
            nv_wr_q <= clean_desel && !locked && pend_lock_q;
        end
    end

    // OTP mode entry and exit on single-byte commands
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            otp_mode_q <= 1'b0;
        end else if (op_enter) begin
            otp_mode_q <= 1'b1;
        end else if (op_exit) begin
            otp_mode_q <= 1'b0;
        end
    end

    // Program into OTP only in mode, unlocked, and inside the 4K-bit window
    assign otp_wr_ok = otp_mode_q && ACC_IN.wr && !locked && region != 2'h2;

    sotp_mem u_mem (
        .clk_in    (CLOCK_IN),
        .wr_in     (otp_wr_ok),
        .addr_in   (ACC_IN.addr[OTP_ADDR_W-1:0]),
        .wdata_in  (ACC_IN.data),
        .rdata_out (OTP_RDATA_OUT)
    );

    // Main array gets no strobe while OTP mode routes accesses away
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            MAIN_ACC_OUT <= '0;
        end else begin
            MAIN_ACC_OUT.wr   <= ACC_IN.wr & ~otp_mode_q;
            MAIN_ACC_OUT.rd   <= ACC_IN.rd & ~otp_mode_q;
            MAIN_ACC_OUT.addr <= ACC_IN.addr;
            MAIN_ACC_OUT.data <= ACC_IN.data;
        end
    end

    // Refusal flag covers blocked OTP programs and off-boundary security writes
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            refused_q <= 1'b0;
        end else begin
            refused_q <= (otp_mode_q && ACC_IN.wr && !otp_wr_ok)
                       || (DESEL_IN && state_q != S_IDLE && state_q != S_SKIP
                           && !(state_q == S_DONE && BIT_CNT_IN == 3'h0));
        end
    end

    assign SEC_REG_OUT    = {6'h00, lock_q, fact_q};
    assign OTP_MODE_OUT   = otp_mode_q;
    assign NV_LOCK_WR_OUT = nv_wr_q;
    assign REFUSED_OUT    = refused_q;

    // Checks: routing of array accesses
    // A main-array write in OTP mode would defeat the routing
    chk_main_wr_block: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        otp_mode_q |=> !MAIN_ACC_OUT.wr)
        else $error("main write passed in OTP mode");
    // Reads in OTP mode belong to the OTP area
    chk_main_rd_block: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        otp_mode_q |=> !MAIN_ACC_OUT.rd)
        else $error("main read passed in OTP mode");
    // Outside OTP mode the strobes reach the main array one cycle late
    chk_main_pass: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !otp_mode_q |=> MAIN_ACC_OUT.wr == $past(ACC_IN.wr)
                        && MAIN_ACC_OUT.rd == $past(ACC_IN.rd))
        else $error("main strobe lost outside OTP mode");
    // Address and data always travel with the strobe
    chk_main_copy: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (ACC_IN.wr || ACC_IN.rd)
        |=> MAIN_ACC_OUT.addr == $past(ACC_IN.addr)
            && MAIN_ACC_OUT.data == $past(ACC_IN.data))
        else $error("main address or data not copied");

    // Checks: OTP programming and lock state
    // Only a power-up restore may rewrite a set lock
    chk_lock_sticky: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (lock_q && !NV_LOAD_IN) |=> lock_q)
        else $error("lock bit cleared");
    // A locked area takes no program and flags the refusal
    chk_locked_no_prog: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (locked && ACC_IN.wr && otp_mode_q) |-> !otp_wr_ok ##1 refused_q)
        else $error("program while locked");
    // Addresses beyond the 4K-bit area are refused
    chk_range_refused: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (otp_mode_q && ACC_IN.wr && region == 2'h2) |-> !otp_wr_ok ##1 refused_q)
        else $error("program outside OTP area");
    // An unlocked program inside the area goes through quietly
    chk_prog_allowed: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (otp_mode_q && ACC_IN.wr && !locked && region != 2'h2 && !DESEL_IN)
        |-> otp_wr_ok ##1 !refused_q)
        else $error("legal program refused");

    // Checks: mode commands and the security write decoder
    // Enter command turns the mode on
    chk_enter_mode: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        op_enter |=> otp_mode_q)
        else $error("enter not taken");
    // Exit command turns the mode off
    chk_exit_mode: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        op_exit |=> !otp_mode_q)
        else $error("exit not taken");
    // Security writes are skipped while in OTP mode
    chk_sec_ignored: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (otp_mode_q && op_wsec && state_q == S_IDLE && !DESEL_IN) |=> state_q == S_SKIP)
        else $error("security write in OTP mode");
    // Outside OTP mode the opcode alone starts the write
    chk_sec_taken: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (!otp_mode_q && op_wsec && state_q == S_IDLE && !DESEL_IN) |=> state_q == S_WSEC)
        else $error("security write not started");
    // Deselect before the data byte leaves the lock alone
    chk_bad_desel: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (DESEL_IN && state_q == S_WSEC && !NV_LOAD_IN) |=> $stable(lock_q) && refused_q)
        else $error("off-boundary write executed");
    // Deselect inside a following byte is rejected too
    chk_off_boundary: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (DESEL_IN && state_q == S_DONE && BIT_CNT_IN != 3'h0 && !NV_LOAD_IN)
        |=> $stable(lock_q) && refused_q)
        else $error("partial byte write executed");
    // A clean write of an unlocked part sets and persists the lock
    chk_good_write: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (clean_desel && pend_lock_q && !locked && !NV_LOAD_IN)
        |=> lock_q && SEC_REG_OUT[LOCK_BIT] && nv_wr_q)
        else $error("lock-down not set");
    // A locked part ignores even a clean security write
    chk_locked_write: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (clean_desel && locked && !NV_LOAD_IN) |=> $stable(lock_q) && !nv_wr_q)
        else $error("lock changed while locked");
    // Persist request is a single-cycle pulse
    chk_nv_pulse: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        nv_wr_q |=> !nv_wr_q)
        else $error("persist pulse too long");
    // Every deselect returns the decoder to idle
    chk_decoder_idle: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        DESEL_IN |=> state_q == S_IDLE)
        else $error("decoder not idle after deselect");
    // Only the lock position of the data byte is kept
    chk_lock_bit_only: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (state_q == S_WSEC && BYTE_IN.valid)
        |=> pend_lock_q == $past(BYTE_IN.data[LOCK_BIT]))
        else $error("wrong data bit kept");
    // Register layout: factory flag in bit 0, reserved bits low
    chk_fact_bit: assert property (
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SEC_REG_OUT[FACT_BIT] == fact_q && SEC_REG_OUT[7:2] == 6'h00)
        else $error("security register layout");

    // Main scenarios, for coverage
    cov_lock_set:  cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) $rose(lock_q));
    cov_otp_prog:  cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) otp_wr_ok);
    cov_refused:   cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) refused_q);
    cov_mode_exit: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) $fell(otp_mode_q));
    cov_bad_desel: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
        DESEL_IN && state_q == S_WSEC);
endmodule : sotp_ctrl
`default_nettype wire

// [rtl/sotp_mem.sv]
// Small OTP cell array, 512 bytes, registered read data.
// Assumes the caller gates writes; a write can only clear bits, like real OTP cells.
`timescale 1ns/1ns
`default_nettype none
module sotp_mem
    import sotp_pkg::*;
(
    input  wire logic                  clk_in,   // Clock
    input  wire logic                  wr_in,    // Program strobe
    input  wire logic [OTP_ADDR_W-1:0] addr_in,  // Byte address
    input  wire logic [7:0]            wdata_in, // Program data
    output logic      [7:0]            rdata_out // Registered read data
);
    logic [7:0] mem [OTP_BYTES];

    // Programming only clears bits, so one-time semantics hold in the array itself
    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= mem[addr_in] & wdata_in;
        end
        rdata_out <= mem[addr_in];
    end

    // Model of blank cells at power-up; a real part keeps them across power
    initial begin
        for (int i = 0; i < OTP_BYTES; i++) begin
            mem[i] = ERASED_BYTE;
        end
    end
endmodule : sotp_mem
`default_nettype wire

// [testbench/sotp_host.sv]
// Host model: sends command bytes and deselect events to the OTP control.
// Assumes the bench calls cmd from one process only, between clock edges.
`timescale 1ns/1ns
`default_nettype none
module sotp_host
    import sotp_pkg::*;
(
    input  wire logic       clk_in,      // Clock
    output sotp_byte_t      byte_out,    // Command bytes
    output logic            desel_out,   // Deselect pulse
    output logic [2:0]      bit_cnt_out  // Bits of partial byte
);
    initial begin
        byte_out = '0;
        desel_out = 1'b0;
        bit_cnt_out = 3'h0;
    end

    // Opcode, optional data byte, deselect at bit count bc
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic has_d,
                       input logic [2:0] bc);
        @(negedge clk_in);
        byte_out = '{1'b1, 1'b1, op};
        @(negedge clk_in);
        byte_out = '{has_d, 1'b0, has_d ? d : ~op};
        @(negedge clk_in);
        // Released byte lane toggles so stale data never looks valid
        byte_out = '{1'b0, 1'b0, ~byte_out.data};
        desel_out = 1'b1;
        bit_cnt_out = bc;
        @(negedge clk_in);
        desel_out = 1'b0;
        bit_cnt_out = 3'h0;
    endtask : cmd
endmodule : sotp_host
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the secured OTP lock control.
// Assumes the host model drives the command side; bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sotp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n, nv_lock, nv_fact, nv_load, desel, otp_mode, nv_lock_wr, refused;
    logic [2:0]  bit_cnt;
    logic [7:0]  otp_rdata, sec_reg, d;
    logic [8:0]  a;
    sotp_acc_t   acc, main_acc;
    sotp_byte_t  byte_w;
    int          bad_count = 0;
    int          comparisons = 0;
    logic [7:0]  exp_mem [OTP_BYTES];

    always #25 clk = ~clk;

    sotp_host u_host (.clk_in(clk), .byte_out(byte_w), .desel_out(desel), .bit_cnt_out(bit_cnt));
    sotp_ctrl u_dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .BYTE_IN(byte_w), .DESEL_IN(desel),
        .BIT_CNT_IN(bit_cnt), .NV_LOCK_IN(nv_lock), .NV_FACT_IN(nv_fact),
        .NV_LOAD_IN(nv_load), .ACC_IN(acc), .MAIN_ACC_OUT(main_acc),
        .OTP_RDATA_OUT(otp_rdata), .SEC_REG_OUT(sec_reg), .OTP_MODE_OUT(otp_mode),
        .NV_LOCK_WR_OUT(nv_lock_wr), .REFUSED_OUT(refused));

    // Cells only ever lose bits; a locked part keeps them
    function automatic logic [7:0] otp_after(input logic [7:0] old, input logic [7:0] dt,
                                             input logic locked);
        return locked ? old : (old & dt);
    endfunction : otp_after

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // One access strobe, then the lane is scrambled
    task automatic access(input logic wr, input logic rd, input logic [23:0] ad,
                          input logic [7:0] dt);
        @(negedge clk);
        acc = '{wr, rd, ad, dt};
        @(negedge clk);
        acc = '{1'b0, 1'b0, ~ad, ~dt};
    endtask : access

    // Reset, then power-up restore of the stored lock bits
    task automatic do_reset(input logic lk, input logic ft);
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        {nv_lock, nv_fact, nv_load} = {lk, ft, 1'b1};
        @(negedge clk);
        {nv_lock, nv_fact, nv_load} = {~lk, ~ft, 1'b0};
        check(sec_reg, {6'h00, lk, ft});
    endtask : do_reset

    // Run far longer than the tests but still bounded
    initial begin
        #(50 * 3000);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {rst_n, nv_lock, nv_fact, nv_load} = 4'h0;
        acc = '0;
        foreach (exp_mem[i]) exp_mem[i] = ERASED_BYTE;
        a = 9'($urandom(43));
        do_reset(1'b0, 1'b0);
        u_host.cmd(OP_WR_SEC, 8'h02, 1'b1, 3'h3);
        check(refused, 1'b1);
        check(sec_reg, 8'h00);
        u_host.cmd(OP_WR_SEC, 8'h02, 1'b0, 3'h0);
        check(refused, 1'b1);
        check(sec_reg, 8'h00);
        u_host.cmd(OP_ENTER_OTP, 8'h00, 1'b0, 3'h0);
        check(otp_mode, 1'b1);
        u_host.cmd(OP_WR_SEC, 8'h02, 1'b1, 3'h0);
        check(sec_reg, 8'h00);
        access(1'b1, 1'b0, 24'h000123, 8'h5a);
        check(main_acc.wr, 1'b0);
        // That write was routed to the OTP cell instead
        exp_mem[9'h123] = otp_after(exp_mem[9'h123], 8'h5a, 1'b0);
        access(1'b0, 1'b1, 24'h000123, 8'h00);
        check(main_acc.rd, 1'b0);
        check(otp_rdata, exp_mem[9'h123]);
        access(1'b1, 1'b0, 24'h000200, 8'h00);
        check(refused, 1'b1);
        // Region edges first, then random cells
        for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? 9'h00f : (i == 1) ? 9'h010 : (i == 2) ? 9'h1ff : 9'($urandom);
            d = 8'($urandom);
            access(1'b1, 1'b0, {15'h0000, a}, d);
            check(refused, 1'b0);
            exp_mem[a] = otp_after(exp_mem[a], d, 1'b0);
            access(1'b0, 1'b1, {15'h0000, a}, 8'h00);
            check(otp_rdata, exp_mem[a]);
        end
        u_host.cmd(OP_EXIT_OTP, 8'h00, 1'b0, 3'h0);
        check(otp_mode, 1'b0);
        access(1'b1, 1'b0, 24'h000123, 8'h5a);
        check(main_acc.wr, 1'b1);
        check(main_acc.addr, 24'h000123);
        check(main_acc.data, 8'h5a);
        access(1'b0, 1'b1, 24'h000456, 8'h00);
        check(main_acc.rd, 1'b1);
        u_host.cmd(OP_WR_SEC, 8'hfd, 1'b1, 3'h0);
        check(sec_reg, 8'h00);
        u_host.cmd(OP_WR_SEC, 8'h02, 1'b1, 3'h0);
        check(sec_reg, 8'h02);
        check(nv_lock_wr, 1'b1);
        @(negedge clk);
        check(nv_lock_wr, 1'b0);
        // Locked part: programs refused, cells unchanged
        u_host.cmd(OP_ENTER_OTP, 8'h00, 1'b0, 3'h0);
        access(1'b1, 1'b0, {15'h0000, a}, 8'h00);
        check(refused, 1'b1);
        access(1'b0, 1'b1, {15'h0000, a}, 8'h00);
        check(otp_rdata, otp_after(exp_mem[a], 8'h00, 1'b1));
        u_host.cmd(OP_EXIT_OTP, 8'h00, 1'b0, 3'h0);
        // Factory lock alone blocks the customer lock and programs
        do_reset(1'b0, 1'b1);
        u_host.cmd(OP_WR_SEC, 8'h02, 1'b1, 3'h0);
        check(sec_reg, 8'h01);
        check(nv_lock_wr, 1'b0);
        u_host.cmd(OP_ENTER_OTP, 8'h00, 1'b0, 3'h0);
        access(1'b1, 1'b0, {15'h0000, a}, 8'h00);
        check(refused, 1'b1);
        u_host.cmd(OP_EXIT_OTP, 8'h00, 1'b0, 3'h0);
        do_reset(1'b1, 1'b1);
        u_host.cmd(OP_WR_SEC, 8'h00, 1'b1, 3'h0);
        check(sec_reg, 8'h03);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
